// ---- src/fer_defines.svh ----
// Constants of the fault event recorder
`ifndef FER_DEFINES_SVH
`define FER_DEFINES_SVH
`define FER_CMD_READ       8'hEE
`define FER_CMD_FORCE      8'hEA
`define FER_CMD_ERASE      8'hEC
`define FER_REC_LEN        8'h93
`define FER_HDR_LEN        8'h1B
`define FER_PAGE_BYTES     8'h14
`define FER_RING_LAST      3'h6
`define FER_B_CODE         8'h00
`define FER_B_TIME_END     8'h06
`define FER_B_VOUT         8'h07
`define FER_B_IOUT         8'h0B
`define FER_B_IIN          8'h0D
`define FER_B_VIN          8'h0F
`define FER_FILL           8'hFF
`define FER_FORCE_CODE     8'hFF
`define FER_SMB_ADDR       7'h30
`define FER_CLK_NS         20
`define FER_TICK_NS        200000
`define FER_TEMP_OFF_C     8'h82
`define FER_TEMP_ON_C      8'h7D
`define FER_CFG_LOG_BIT    7
`define FER_VSTAT_SAVE_BIT 3
`define FER_CFG_RST        16'h0080
`define FER_OFF_CFG        8'h00
`define FER_OFF_VSTAT      8'h04
`define FER_OFF_STATE      8'h08
`define FER_OFF_UPT_LO     8'h0C
`define FER_OFF_UPT_HI     8'h10
`define FER_RESP_OKAY      2'h0
`define FER_RESP_SLVERR    2'h2
`endif

// ---- src/fer_pkg.sv ----
// Types of the fault event recorder
package fer_pkg;
	typedef logic [7:0] fer_byte_t;
	typedef enum logic [2:0] {SMB_IDLE, SMB_ADDR, SMB_AACK, SMB_WR, SMB_RD, SMB_RACK} fer_smb_state_t;
	typedef enum logic {CAP_IDLE, CAP_COPY} fer_cap_state_t;
endpackage

// ---- src/fer_link_if.sv ----
// Byte link between serial slave and recorder
`timescale 1ns/100ps
`default_nettype none
interface fer_link_if;
	logic              rx_valid;
	fer_pkg::fer_byte_t rx_data;
	logic              rx_cmd;
	logic              stop;
	logic              tx_take;
	fer_pkg::fer_byte_t tx_data;
	modport slv (output rx_valid, rx_data, rx_cmd, stop, tx_take, input tx_data);
	modport app (input rx_valid, rx_data, rx_cmd, stop, tx_take, output tx_data);
endinterface
`default_nettype wire

// ---- src/fer_smbus.sv ----
// Serial bus byte slave, pins sampled by the system clock
`include "fer_defines.svh"
`timescale 1ns/100ps
`default_nettype none
module fer_smbus (
	input  wire logic sys_clk,
	input  wire logic nrst,
	input  wire logic scl_in,
	input  wire logic sda_in,
	output logic      sda_drive_n,
	fer_link_if.slv   link
);
	import fer_pkg::*;

	logic [1:0]     meta_reg;
	logic [1:0]     sync_reg;
	logic [1:0]     prev_reg;
	fer_smb_state_t st_reg;
	fer_byte_t      sh_reg;
	fer_byte_t      tx_reg;
	logic [2:0]     cnt_reg;
	logic           full_reg;
	logic           rd_reg;
	logic           first_reg;
	logic           scl;
	logic           sda;
	logic           rise;
	logic           fall;
	logic           start;
	logic           stop;

	// ----------------------------------------
	// Pin synchronisers and line events
	// ----------------------------------------
	always_ff @(posedge sys_clk or negedge nrst) begin
		if (!nrst) begin
			meta_reg <= 2'h3;
			sync_reg <= 2'h3;
			prev_reg <= 2'h3;
		end else begin
			meta_reg <= {scl_in, sda_in};
			sync_reg <= meta_reg;
			prev_reg <= sync_reg;
		end
	end

	assign scl   = sync_reg[1];
	assign sda   = sync_reg[0];
	assign rise  = scl & ~prev_reg[1];
	assign fall  = ~scl & prev_reg[1];
	assign start = scl & prev_reg[1] & prev_reg[0] & ~sda;
	assign stop  = scl & prev_reg[1] & ~prev_reg[0] & sda;

	// ----------------------------------------
	// Bit and byte sequencer
	// ----------------------------------------
	always_ff @(posedge sys_clk or negedge nrst) begin
		if (!nrst) begin
			st_reg       <= SMB_IDLE;
			sh_reg       <= 8'h00;
			tx_reg       <= 8'h00;
			cnt_reg      <= 3'h0;
			full_reg     <= 1'b0;
			rd_reg       <= 1'b0;
			first_reg    <= 1'b0;
			sda_drive_n  <= 1'b1;
			link.rx_valid <= 1'b0;
			link.rx_data <= 8'h00;
			link.rx_cmd  <= 1'b0;
			link.stop    <= 1'b0;
			link.tx_take <= 1'b0;
		end else begin
			link.rx_valid <= 1'b0;
			link.stop    <= 1'b0;
			link.tx_take <= 1'b0;
			if (start) begin
				st_reg      <= SMB_ADDR;
				cnt_reg     <= 3'h0;
				full_reg    <= 1'b0;
				first_reg   <= 1'b1;
				sda_drive_n <= 1'b1;
			end else if (stop) begin
				st_reg      <= SMB_IDLE;
				sda_drive_n <= 1'b1;
				link.stop   <= 1'b1;
			end else if (rise) begin
				case (st_reg)
					SMB_ADDR, SMB_WR: begin
						sh_reg   <= {sh_reg[6:0], sda};
						cnt_reg  <= cnt_reg + 3'h1;
						full_reg <= (cnt_reg == 3'h7);
					end
					SMB_RACK: begin
						if (sda) begin
							st_reg <= SMB_IDLE;
						end
					end
					default: begin
					end
				endcase
			end else if (fall) begin
				case (st_reg)
					SMB_ADDR: begin
						if (full_reg && sh_reg[7:1] == `FER_SMB_ADDR) begin
							st_reg      <= SMB_AACK;
							rd_reg      <= sh_reg[0];
							sda_drive_n <= 1'b0;
						end else if (full_reg) begin
							st_reg <= SMB_IDLE;
						end
					end
					SMB_WR: begin
						if (full_reg) begin
							st_reg       <= SMB_AACK;
							sda_drive_n  <= 1'b0;
							link.rx_valid <= 1'b1;
							link.rx_data <= sh_reg;
							link.rx_cmd  <= first_reg;
							first_reg    <= 1'b0;
						end
					end
					SMB_AACK, SMB_RACK: begin
						full_reg <= 1'b0;
						cnt_reg  <= 3'h0;
						if (rd_reg) begin
							st_reg       <= SMB_RD;
							tx_reg       <= link.tx_data;
							link.tx_take <= 1'b1;
							sda_drive_n  <= link.tx_data[7];
						end else begin
							st_reg      <= SMB_WR;
							sda_drive_n <= 1'b1;
						end
					end
					SMB_RD: begin
						cnt_reg <= cnt_reg + 3'h1;
						if (cnt_reg == 3'h7) begin
							st_reg      <= SMB_RACK;
							sda_drive_n <= 1'b1;
						end else begin
							sda_drive_n <= tx_reg[3'h6 - cnt_reg];
						end
					end
					default: begin
					end
				endcase
			end
		end
	end
endmodule
`default_nettype wire

// ---- src/fer_top.sv ----
// Fault event recorder: capture, record store, serial read-out, register slave
`include "fer_defines.svh"
`timescale 1ns/100ps
`default_nettype none
module fer_top #(
	parameter int unsigned TICK_CYCLES = `FER_TICK_NS / `FER_CLK_NS
) (
	input  wire logic               sys_clk,
	input  wire logic               nrst,
	input  wire logic [7:0]         s_axi_awaddr,
	input  wire logic               s_axi_awvalid,
	output logic                    s_axi_awready,
	input  wire logic [31:0]        s_axi_wdata,
	input  wire logic [3:0]         s_axi_wstrb,
	input  wire logic               s_axi_wvalid,
	output logic                    s_axi_wready,
	output logic [1:0]              s_axi_bresp,
	output logic                    s_axi_bvalid,
	input  wire logic               s_axi_bready,
	input  wire logic [7:0]         s_axi_araddr,
	input  wire logic               s_axi_arvalid,
	output logic                    s_axi_arready,
	output logic [31:0]             s_axi_rdata,
	output logic [1:0]              s_axi_rresp,
	output logic                    s_axi_rvalid,
	input  wire logic               s_axi_rready,
	input  wire logic               scl_in,
	input  wire logic               sda_in,
	output logic                    sda_out,
	output logic                    sda_drive_n,
	input  wire logic               fault_evt,
	input  wire fer_pkg::fer_byte_t fault_code,
	input  wire fer_pkg::fer_byte_t die_temp,
	input  wire logic               tele_valid,
	input  wire fer_pkg::fer_byte_t tele_data,
	output logic                    tele_ready,
	input  wire logic [15:0]        out_volt_max,
	input  wire logic [15:0]        out_curr_max,
	input  wire logic [15:0]        in_curr_max,
	input  wire logic [15:0]        in_volt_max,
	output logic                    record_valid,
	output logic                    capture_busy
);
	import fer_pkg::*;

	logic [15:0]    cfg_reg;
	fer_byte_t      vstat_reg;
	logic           hot_reg;
	logic [31:0]    presc_reg;
	logic [47:0]    uptime_reg;
	fer_byte_t      nvm [0:146];
	fer_byte_t      ring [0:139];
	logic           nvm_valid_reg;
	fer_cap_state_t cap_reg;
	logic [7:0]     cp_idx_reg;
	fer_byte_t      code_reg;
	logic [47:0]    stamp_reg;
	logic [2:0]     tw_page_reg;
	logic [2:0]     newest_reg;
	logic [4:0]     tw_byte_reg;
	fer_byte_t      cmd_reg;
	logic           cmd_pend_reg;
	logic           data_seen_reg;
	logic [7:0]     rd_idx_reg;
	logic [7:0]     rd_len_reg;
	logic           aw_have_reg;
	logic           w_have_reg;
	logic [7:0]     awaddr_reg;
	logic [31:0]    wdata_reg;
	logic [3:0]     wstrb_reg;
	logic           log_en;
	logic           cmd_done;
	logic           force_req;
	logic           erase_req;
	logic           force_ok;
	logic           cap_start;
	logic           wr_go;
	fer_byte_t      vstat_clr;
	fer_byte_t      cp_src;
	logic [7:0]     rel;
	logic [7:0]     page;
	logic [7:0]     off;
	logic [2:0]     slot;

	fer_link_if link ();

	fer_smbus u_smb (
		.sys_clk    (sys_clk),
		.nrst       (nrst),
		.scl_in     (scl_in),
		.sda_in     (sda_in),
		.sda_drive_n(sda_drive_n),
		.link       (link.slv)
	);

	assign sda_out      = 1'b0;
	assign record_valid = nvm_valid_reg;
	assign capture_busy = (cap_reg == CAP_COPY);
	assign tele_ready   = (cap_reg == CAP_IDLE);

	// ----------------------------------------
	// Uptime and temperature
	// ----------------------------------------
	always_ff @(posedge sys_clk or negedge nrst) begin
		if (!nrst) begin
			presc_reg  <= 32'h0;
			uptime_reg <= 48'h0;
		end else if (presc_reg == TICK_CYCLES - 1) begin
			presc_reg  <= 32'h0;
			uptime_reg <= uptime_reg + 48'h1;
		end else begin
			presc_reg <= presc_reg + 32'h1;
		end
	end

	always_ff @(posedge sys_clk or negedge nrst) begin
		if (!nrst) begin
			hot_reg <= 1'b0;
		end else if (die_temp > `FER_TEMP_OFF_C) begin
			hot_reg <= 1'b1;
		end else if (die_temp < `FER_TEMP_ON_C) begin
			hot_reg <= 1'b0;
		end
	end

	// ----------------------------------------
	// Serial commands
	// ----------------------------------------
	assign log_en    = cfg_reg[`FER_CFG_LOG_BIT];
	assign cmd_done  = link.stop && cmd_pend_reg && !data_seen_reg;
	assign force_req = cmd_done && cmd_reg == `FER_CMD_FORCE;
	assign erase_req = cmd_done && cmd_reg == `FER_CMD_ERASE;
	assign force_ok  = force_req && !hot_reg;
	assign cap_start = log_en && (fault_evt || force_ok)
		&& cap_reg == CAP_IDLE && !nvm_valid_reg;

	always_ff @(posedge sys_clk or negedge nrst) begin
		if (!nrst) begin
			cmd_reg       <= 8'h00;
			cmd_pend_reg  <= 1'b0;
			data_seen_reg <= 1'b0;
			rd_idx_reg    <= 8'h00;
			rd_len_reg    <= 8'h00;
		end else if (link.rx_valid && link.rx_cmd) begin
			cmd_reg       <= link.rx_data;
			cmd_pend_reg  <= 1'b1;
			data_seen_reg <= 1'b0;
			rd_idx_reg    <= 8'h00;
			rd_len_reg    <= nvm_valid_reg ? `FER_REC_LEN : 8'h00;
		end else begin
			if (link.rx_valid) begin
				data_seen_reg <= 1'b1;
			end
			if (link.stop) begin
				cmd_pend_reg <= 1'b0;
			end
			if (link.tx_take && rd_idx_reg != 8'hFF) begin
				rd_idx_reg <= rd_idx_reg + 8'h01;
			end
		end
	end

	always_ff @(posedge sys_clk or negedge nrst) begin
		if (!nrst) begin
			link.tx_data <= `FER_FILL;
		end else if (cmd_reg != `FER_CMD_READ) begin
			link.tx_data <= `FER_FILL;
		end else if (rd_idx_reg == 8'h00) begin
			link.tx_data <= rd_len_reg;
		end else if (rd_idx_reg <= rd_len_reg) begin
			link.tx_data <= nvm[rd_idx_reg - 8'h01];
		end else begin
			link.tx_data <= `FER_FILL;
		end
	end

	// ----------------------------------------
	// Telemetry ring, seven pages so six stay complete
	// ----------------------------------------
	always_ff @(posedge sys_clk) begin
		if (tele_valid && tele_ready) begin
			ring[8'(tw_page_reg) * `FER_PAGE_BYTES + 8'(tw_byte_reg)] <= tele_data;
		end
	end

	always_ff @(posedge sys_clk or negedge nrst) begin
		if (!nrst) begin
			tw_page_reg <= 3'h0;
			tw_byte_reg <= 5'h00;
			newest_reg  <= 3'h0;
		end else if (tele_valid && tele_ready) begin
			if (8'(tw_byte_reg) == `FER_PAGE_BYTES - 8'h01) begin
				tw_byte_reg <= 5'h00;
				newest_reg  <= tw_page_reg;
				tw_page_reg <= (tw_page_reg == `FER_RING_LAST) ? 3'h0 : tw_page_reg + 3'h1;
			end else begin
				tw_byte_reg <= tw_byte_reg + 5'h01;
			end
		end
	end

	// ----------------------------------------
	// Record capture into the history store
	// ----------------------------------------
	always_comb begin
		rel    = cp_idx_reg - `FER_HDR_LEN;
		page   = rel / `FER_PAGE_BYTES;
		off    = rel % `FER_PAGE_BYTES;
		slot   = (newest_reg >= page[2:0]) ? newest_reg - page[2:0]
			: newest_reg + `FER_RING_LAST + 3'h1 - page[2:0];
		cp_src = 8'h00;
		if (cp_idx_reg == `FER_B_CODE) begin
			cp_src = code_reg;
		end else if (cp_idx_reg <= `FER_B_TIME_END) begin
			cp_src = stamp_reg[{cp_idx_reg[2:0] - 3'h1, 3'h0} +: 8];
		end else if (cp_idx_reg >= `FER_HDR_LEN) begin
			cp_src = ring[8'(slot) * `FER_PAGE_BYTES + off];
		end else begin
			case (cp_idx_reg)
				`FER_B_VOUT:          cp_src = out_volt_max[15:8];
				`FER_B_VOUT + 8'h01:  cp_src = out_volt_max[7:0];
				`FER_B_IOUT:          cp_src = out_curr_max[15:8];
				`FER_B_IOUT + 8'h01:  cp_src = out_curr_max[7:0];
				`FER_B_IIN:           cp_src = in_curr_max[15:8];
				`FER_B_IIN + 8'h01:   cp_src = in_curr_max[7:0];
				`FER_B_VIN:           cp_src = in_volt_max[15:8];
				`FER_B_VIN + 8'h01:   cp_src = in_volt_max[7:0];
				default:              cp_src = 8'h00;
			endcase
		end
	end

	always_ff @(posedge sys_clk) begin
		if (cap_reg == CAP_COPY) begin
			nvm[cp_idx_reg] <= cp_src;
		end
	end

	always_ff @(posedge sys_clk or negedge nrst) begin
		if (!nrst) begin
			cap_reg       <= CAP_IDLE;
			cp_idx_reg    <= 8'h00;
			code_reg      <= 8'h00;
			stamp_reg     <= 48'h0;
			nvm_valid_reg <= 1'b0;
		end else begin
			case (cap_reg)
				CAP_IDLE: begin
					if (cap_start) begin
						cap_reg    <= CAP_COPY;
						cp_idx_reg <= 8'h00;
						code_reg   <= fault_evt ? fault_code : `FER_FORCE_CODE;
						stamp_reg  <= uptime_reg;
					end else if (erase_req) begin
						nvm_valid_reg <= 1'b0;
					end
				end
				CAP_COPY: begin
					cp_idx_reg <= cp_idx_reg + 8'h01;
					if (cp_idx_reg == `FER_REC_LEN - 8'h01) begin
						cap_reg       <= CAP_IDLE;
						nvm_valid_reg <= 1'b1;
					end
				end
				default: cap_reg <= CAP_IDLE;
			endcase
		end
	end

	// ----------------------------------------
	// Register slave
	// ----------------------------------------
	assign s_axi_awready = !aw_have_reg && !s_axi_bvalid;
	assign s_axi_wready  = !w_have_reg && !s_axi_bvalid;
	assign s_axi_arready = !s_axi_rvalid;
	assign wr_go         = aw_have_reg && w_have_reg;
	assign vstat_clr     = (wr_go && awaddr_reg == `FER_OFF_VSTAT && wstrb_reg[0])
		? wdata_reg[7:0] : 8'h00;

	always_ff @(posedge sys_clk or negedge nrst) begin
		if (!nrst) begin
			aw_have_reg  <= 1'b0;
			w_have_reg   <= 1'b0;
			awaddr_reg   <= 8'h00;
			wdata_reg    <= 32'h0;
			wstrb_reg    <= 4'h0;
			s_axi_bvalid <= 1'b0;
			s_axi_bresp  <= `FER_RESP_OKAY;
		end else if (wr_go) begin
			aw_have_reg  <= 1'b0;
			w_have_reg   <= 1'b0;
			s_axi_bvalid <= 1'b1;
			s_axi_bresp  <= (awaddr_reg == `FER_OFF_CFG || awaddr_reg == `FER_OFF_VSTAT)
				? `FER_RESP_OKAY : `FER_RESP_SLVERR;
		end else begin
			if (s_axi_awvalid && s_axi_awready) begin
				aw_have_reg <= 1'b1;
				awaddr_reg  <= s_axi_awaddr;
			end
			if (s_axi_wvalid && s_axi_wready) begin
				w_have_reg <= 1'b1;
				wdata_reg  <= s_axi_wdata;
				wstrb_reg  <= s_axi_wstrb;
			end
			if (s_axi_bvalid && s_axi_bready) begin
				s_axi_bvalid <= 1'b0;
			end
		end
	end

	always_ff @(posedge sys_clk or negedge nrst) begin
		if (!nrst) begin
			cfg_reg   <= `FER_CFG_RST;
			vstat_reg <= 8'h00;
		end else begin
			if (wr_go && awaddr_reg == `FER_OFF_CFG && wstrb_reg[0]) begin
				cfg_reg[7:0] <= wdata_reg[7:0];
			end
			if (wr_go && awaddr_reg == `FER_OFF_CFG && wstrb_reg[1]) begin
				cfg_reg[15:8] <= wdata_reg[15:8];
			end
			vstat_reg <= (vstat_reg & ~vstat_clr)
				| {4'h0, force_ok && log_en, 3'h0};
		end
	end

	always_ff @(posedge sys_clk or negedge nrst) begin
		if (!nrst) begin
			s_axi_rvalid <= 1'b0;
			s_axi_rdata  <= 32'h0;
			s_axi_rresp  <= `FER_RESP_OKAY;
		end else if (s_axi_arvalid && s_axi_arready) begin
			s_axi_rvalid <= 1'b1;
			s_axi_rresp  <= `FER_RESP_OKAY;
			case (s_axi_araddr)
				`FER_OFF_CFG:    s_axi_rdata <= {16'h0, cfg_reg};
				`FER_OFF_VSTAT:  s_axi_rdata <= {24'h0, vstat_reg};
				`FER_OFF_STATE:  s_axi_rdata <= {29'h0, hot_reg, capture_busy, nvm_valid_reg};
				`FER_OFF_UPT_LO: s_axi_rdata <= uptime_reg[31:0];
				`FER_OFF_UPT_HI: s_axi_rdata <= {16'h0, uptime_reg[47:32]};
				default: begin
					s_axi_rdata <= 32'h0;
					s_axi_rresp <= `FER_RESP_SLVERR;
				end
			endcase
		end else if (s_axi_rready) begin
			s_axi_rvalid <= 1'b0;
		end
	end

	// ----------------------------------------
	// Checks
	// ----------------------------------------
	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (!nrst);

	property p_len_full;
		link.rx_valid && link.rx_cmd && nvm_valid_reg |=> rd_len_reg == `FER_REC_LEN;
	endproperty
	a_len_full: assert property (p_len_full)
		else $error("stored record length is not 147");
	property p_len_empty;
		link.rx_valid && link.rx_cmd && !nvm_valid_reg |=> rd_len_reg == 8'h00;
	endproperty
	a_len_empty: assert property (p_len_empty)
		else $error("empty history length is not zero");
	property p_lock;
		nvm_valid_reg && !erase_req |=> nvm_valid_reg && !capture_busy;
	endproperty
	a_lock: assert property (p_lock)
		else $error("locked record lost or overwritten");
	property p_erase;
		erase_req && cap_reg == CAP_IDLE |=> !nvm_valid_reg;
	endproperty
	a_erase: assert property (p_erase)
		else $error("erase left record present");
	property p_store_time;
		cap_start |-> ##148 nvm_valid_reg;
	endproperty
	a_store_time: assert property (p_store_time)
		else $error("record not complete 148 cycles after capture");
	property p_no_partial;
		cap_start |=> (capture_busy && !nvm_valid_reg)[*8];
	endproperty
	a_no_partial: assert property (p_no_partial)
		else $error("record visible while store is running");
	property p_newest;
		cap_reg == CAP_COPY && cp_idx_reg == `FER_HDR_LEN
			|=> nvm[`FER_HDR_LEN] == ring[8'(newest_reg) * `FER_PAGE_BYTES];
	endproperty
	a_newest: assert property (p_newest)
		else $error("newest cycle not in first slot");
	property p_save_flag;
		force_req && log_en && !hot_reg |=> vstat_reg[`FER_VSTAT_SAVE_BIT];
	endproperty
	a_save_flag: assert property (p_save_flag)
		else $error("force-save did not set status bit 3");
	property p_hot;
		hot_reg && die_temp >= `FER_TEMP_ON_C |=> hot_reg;
	endproperty
	a_hot: assert property (p_hot)
		else $error("hot lockout released above 125 C");
	property p_tick;
		presc_reg == TICK_CYCLES - 1 |=> uptime_reg == $past(uptime_reg) + 48'h1;
	endproperty
	a_tick: assert property (p_tick)
		else $error("uptime did not advance on tick");

	c_capture: cover property (cap_start ##1 capture_busy);
	c_force_hot: cover property (force_req && hot_reg);
	c_erase: cover property (erase_req && nvm_valid_reg);
	c_full_read: cover property (rd_len_reg == `FER_REC_LEN && rd_idx_reg == 8'h94);
endmodule
`default_nettype wire

// ---- testbench/fer_host.sv ----
// Serial bus host model reading the event history
`timescale 1ns/100ps
`default_nettype none
module fer_host (
	output logic      scl,
	output logic      sda_pull,
	input  wire logic sda
);
	// Quarter period of the 160 ns serial clock
	localparam int Q = 40;
	initial begin
		scl = 1'b1;
		sda_pull = 1'b0;
	end
	task automatic start();
		#Q sda_pull <= 1'b0;
		#Q scl <= 1'b1;
		#Q sda_pull <= 1'b1;
		#Q scl <= 1'b0;
	endtask
	task automatic stop();
		#Q sda_pull <= 1'b1;
		#Q scl <= 1'b1;
		#Q sda_pull <= 1'b0;
		#Q;
	endtask
	// Eight data bits, then the acknowledge slot
	task automatic xfer(input logic [7:0] tx, input logic ai,
		output logic [7:0] rx, output logic ao);
		logic [8:0] sh;
		sh = {tx, ai};
		for (int i = 8; i >= 0; i--) begin
			#Q sda_pull <= !sh[i];
			#Q scl <= 1'b1;
			#Q sh[i] = sda;
			#Q scl <= 1'b0;
		end
		rx = sh[8:1];
		ao = sh[0];
	endtask
endmodule
`default_nettype wire

// ---- testbench/test_fault_event_recorder.sv ----
// Self-checking bench of the fault event recorder
`include "fer_defines.svh"
`timescale 1ns/100ps
`default_nettype none
module test_fault_event_recorder;
	import fer_pkg::*;
	localparam logic [7:0] AW = {`FER_SMB_ADDR, 1'b0};
	logic        sys_clk = 1'b0, nrst = 1'b0;
	logic [7:0]  awaddr = 8'h00, araddr = 8'h00;
	logic [31:0] wdata = 32'h0, rdata;
	logic        awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
	logic        arvalid = 1'b0, rready = 1'b0, fault_evt = 1'b0, tele_valid = 1'b0;
	logic        awready, wready, bvalid, arready, rvalid, tele_ready;
	logic        scl, sda_pull, sda_drive_n, record_valid, capture_busy;
	logic [1:0]  bresp, rresp;
	fer_byte_t   fault_code = 8'h00, die_temp = 8'h00, tele_data = 8'h00;
	logic [15:0] pk [4] = '{default: 16'h0};
	int          seed = 32'h561B, fails = 0, checks_done = 0;
	logic [7:0]  tq[$], rq[$];
	wire         sda = !sda_pull && sda_drive_n;
	always #10 sys_clk = !sys_clk;
	fer_host host (.scl(scl), .sda_pull(sda_pull), .sda(sda));
	fer_top #(.TICK_CYCLES(10)) dut (.sys_clk(sys_clk), .nrst(nrst),
		.s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
		.s_axi_wdata(wdata), .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid),
		.s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
		.s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
		.s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
		.s_axi_rvalid(rvalid), .s_axi_rready(rready), .scl_in(scl), .sda_in(sda),
		.sda_out(), .sda_drive_n(sda_drive_n), .fault_evt(fault_evt),
		.fault_code(fault_code), .die_temp(die_temp), .tele_valid(tele_valid),
		.tele_data(tele_data), .tele_ready(tele_ready), .out_volt_max(pk[0]),
		.out_curr_max(pk[1]), .in_curr_max(pk[2]), .in_volt_max(pk[3]),
		.record_valid(record_valid), .capture_busy(capture_busy));
	task automatic chk(input logic [47:0] g, input logic [47:0] e);
		checks_done++;
		if (g !== e) begin
			fails++;
			$display("MISMATCH t=%0t got=%h exp=%h", $time, g, e);
		end
	endtask
	task automatic axw(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
		logic ta, tw, tb;
		@(posedge sys_clk);
		awaddr <= a;
		wdata <= d;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		do begin
			@(negedge sys_clk);
			ta = awvalid && awready;
			tw = wvalid && wready;
			tb = bvalid;
			r = bresp;
			@(posedge sys_clk);
			if (ta) awvalid <= 1'b0;
			if (tw) wvalid <= 1'b0;
		end while (!tb);
		bready <= 1'b0;
	endtask
	task automatic axr(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
		logic ta, tb;
		@(posedge sys_clk);
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		do begin
			@(negedge sys_clk);
			ta = arvalid && arready;
			tb = rvalid;
			d = rdata;
			r = rresp;
			@(posedge sys_clk);
			if (ta) arvalid <= 1'b0;
		end while (!tb);
		rready <= 1'b0;
	endtask
	task automatic feed(input int n);
		logic t;
		fer_byte_t v;
		@(posedge sys_clk);
		for (int i = 0; i < n; i++) begin
			v = 8'($random(seed));
			tele_data <= v;
			tele_valid <= 1'b1;
			do begin
				@(negedge sys_clk);
				t = tele_ready;
				@(posedge sys_clk);
			end while (!t);
			tq.push_back(v);
		end
		tele_valid <= 1'b0;
	endtask
	task automatic fault(input fer_byte_t c);
		@(posedge sys_clk);
		fault_evt <= 1'b1;
		fault_code <= c;
		@(posedge sys_clk);
		fault_evt <= 1'b0;
	endtask
	task automatic send_cmd(input fer_byte_t cmd);
		logic [7:0] b;
		logic a;
		host.start();
		host.xfer(AW, 1'b1, b, a);
		host.xfer(cmd, 1'b1, b, a);
		chk(a, 1'b0);
		host.stop();
	endtask
	task automatic rd_blk(input int n);
		logic [7:0] b;
		logic a;
		rq = {};
		host.start();
		host.xfer(AW, 1'b1, b, a);
		host.xfer(`FER_CMD_READ, 1'b1, b, a);
		host.start();
		host.xfer(AW | 8'h01, 1'b1, b, a);
		chk(a, 1'b0);
		for (int i = 0; i <= n; i++) begin
			host.xfer(8'hFF, i == n, b, a);
			rq.push_back(b);
		end
		host.stop();
	endtask
	task automatic wait_rec();
		for (int n = 0; n < 400 && record_valid !== 1'b1; n++) @(negedge sys_clk);
		chk(record_valid, 1'b1);
	endtask
	task automatic complete_run();
		$display("Comparisons %0d, mismatches %0d", checks_done, fails);
		if (fails == 0 && checks_done > 0) begin
			$display("All checks passed");
		end else begin
			$display("Checks failed");
		end
		$finish;
	endtask
	initial begin
		#1000000;
		fails++;
		complete_run();
	end
	initial begin
		logic [31:0] d;
		logic [1:0] r;
		fer_byte_t c;
		repeat (5) @(posedge sys_clk);
		nrst <= 1'b1;
		rd_blk(0);
		chk(rq[0], 8'h00);
		axr(`FER_OFF_CFG, d, r);
		chk(d, `FER_CFG_RST);
		axr(8'h20, d, r);
		chk(r, `FER_RESP_SLVERR);
		foreach (pk[i]) pk[i] <= 16'($random(seed));
		c = 8'($random(seed)) & 8'h7F;
		feed(150);
		axr(`FER_OFF_UPT_LO, d, r);
		fault(c);
		@(negedge sys_clk);
		chk({capture_busy, tele_ready, record_valid}, 3'b100);
		wait_rec();
		fault(c ^ 8'hFF);
		rd_blk(147);
		chk(rq[0], `FER_REC_LEN);
		chk(rq[1], c);
		chk({rq[7], rq[6], rq[5], rq[4], rq[3], rq[2]} - d < 48'h2, 1'b1);
		chk({rq[8], rq[9], rq[10], rq[11]}, {pk[0], 16'h0});
		chk({rq[12], rq[13], rq[14], rq[15]}, {pk[1], pk[2]});
		chk({rq[16], rq[17]}, pk[3]);
		for (int i = 0; i < 120; i++) chk(rq[28 + i], tq[120 - i / 20 * 20 + i % 20]);
		send_cmd(`FER_CMD_ERASE);
		rd_blk(0);
		chk(rq[0], 8'h00);
		for (int k = 0; k < 3; k++) begin
			@(posedge sys_clk);
			die_temp <= (k == 0) ? 8'h83 : (k == 1) ? 8'h7E : 8'h7C;
			send_cmd(`FER_CMD_FORCE);
			repeat (200) @(posedge sys_clk);
			axr(`FER_OFF_VSTAT, d, r);
			chk(d[3], k == 2);
			axr(`FER_OFF_STATE, d, r);
			chk(d[2:0], (k == 2) ? 3'h1 : 3'h4);
		end
		rd_blk(1);
		chk({rq[0], rq[1]}, {`FER_REC_LEN, `FER_FORCE_CODE});
		send_cmd(`FER_CMD_ERASE);
		axw(`FER_OFF_VSTAT, 32'h8, r);
		axw(`FER_OFF_CFG, 32'h0, r);
		chk(r, `FER_RESP_OKAY);
		send_cmd(`FER_CMD_FORCE);
		repeat (200) @(posedge sys_clk);
		axr(`FER_OFF_VSTAT, d, r);
		chk(d[3], 1'b0);
		axr(`FER_OFF_STATE, d, r);
		chk(d[0], 1'b0);
		complete_run();
	end
endmodule
`default_nettype wire
